// ===== logic/bwm_ctl.sv
// bandwidth monitor control: control register, counters, snapshots.
// assumes a single-cycle register port and one traffic beat per cycle.
module bwm_ctl #(
  parameter logic HAS_CAPTURE = 1'b1,
  parameter logic HAS_OFLOW = 1'b1,
  parameter logic HAS_INTR = 1'b1,
  parameter logic HAS_LONG = 1'b1,
  parameter logic HAS_CAW = 1'b1,      // snapshot on wrap supported
  parameter logic HAS_LNKG = 1'b1,     // wrap_linkage_supported
  parameter logic [5:0] EXT_PRESENT = 6'h3F,
  parameter logic [4:0] SCALE = 5'h00,
  parameter int PART_W = 16,
  parameter int GRP_W = 8
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  // register port
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [11:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  output logic [31:0] REG_RDATA_O,
  // labelled traffic
  input wire logic BEAT_VALID_I,
  input wire logic [15:0] BEAT_BYTES_I,
  input wire logic [PART_W-1:0] BEAT_PARTITION_LABEL_I,
  input wire logic [GRP_W-1:0] BEAT_MONITOR_GROUP_LABEL_I,
  input wire logic NOT_READY_FLAG_I,
  // capture events
  input wire logic [5:0] EXT_CAPTURE_I,
  input wire logic SW_TRIGGER_OWN_STATE_I,
  output logic [5:0] LINK_CAPTURE_O,
  // interrupt
  output logic SHORT_WRAP_IRQ_O
);
  // -------------------------------------------------------------------------
  // local widths and field positions
  // -------------------------------------------------------------------------
  localparam int SCNT_W_L = bwm_pkg::SCNT_W; // short counter width
  localparam int SUB_HI = 22; // subtype field, always zero
  localparam int SUB_LO = 20;
  localparam int RSV_HI = 12; // reserved pair below the long snapshot bit
  localparam int RSV_LO = 11;
  localparam int B_LIRQ = 14; // long wrap interrupt enable, not built here
  localparam int TYPE_HI = 7; // top bit of the read-only monitor type
  localparam int FLT_GRP_HI = 23; // filter: monitor group label field
  localparam int FLT_GRP_LO = 16;
  localparam int FLT_PART_HI = 15; // filter: partition label field
  localparam int FLT_PART_LO = 0;

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  logic [31:0] ctl_q;                     // writable control bits
  logic [31:0] flt_q;                     // filter register
  logic [SCNT_W_L-1:0] scnt_q;            // short counter
  logic [bwm_pkg::LCNT_W-1:0] lcnt_q;     // long counter
  logic [31:0] scap_q;                    // short snapshot incl. not-ready
  logic [63:0] lcap_q;                    // long snapshot incl. not-ready
  logic sfrz_q;                           // short counter frozen
  logic lfrz_q;                           // long counter frozen

  // -------------------------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------------------------
  // register write hit; the bus signals are arguments so that a continuous
  // assignment using it re-evaluates whenever the strobe or address moves
  function automatic logic hit(input logic wr, input logic [11:0] addr, input logic [11:0] off);
    hit = wr && (addr == off);
  endfunction

  // control value as software sees it, with unsupported fields forced to zero
  function automatic logic [31:0] ctl_view(input logic [31:0] c);
    logic [31:0] v;
    v = c;
    v[SUB_HI:SUB_LO] = 3'h0;
    v[RSV_HI:RSV_LO] = 2'h0;
    v[B_LIRQ] = 1'b0;
    v[TYPE_HI:0] = bwm_pkg::MON_TYPE;
    if (!HAS_CAPTURE)
    begin
      v[bwm_pkg::B_SEL_HI:bwm_pkg::B_SEL_LO] = 3'h0;
      v[bwm_pkg::B_CLR] = 1'b0;
    end
    if (!HAS_OFLOW)
    begin
      v[bwm_pkg::B_SWF] = 1'b0;
      v[bwm_pkg::B_FRZ] = 1'b0;
    end
    if (!HAS_OFLOW || !HAS_INTR)
      v[bwm_pkg::B_SIE] = 1'b0;
    if (!HAS_CAW)
    begin
      v[bwm_pkg::B_SNAP] = 1'b0;
      v[bwm_pkg::B_LSNAP] = 1'b0;
    end
    if (!HAS_LNKG)
    begin
      v[bwm_pkg::B_CAW] = 1'b0;
      v[bwm_pkg::B_LNK_HI:bwm_pkg::B_LNK_LO] = 3'h0;
    end
    if (!HAS_LONG)
    begin
      v[bwm_pkg::B_LWF] = 1'b0;
      v[bwm_pkg::B_LSNAP] = 1'b0;
    end
    ctl_view = v;
  endfunction

  // -------------------------------------------------------------------------
  // event logic
  // -------------------------------------------------------------------------
  logic [31:0] cv;          // effective control
  logic [2:0] sel;          // capture source
  logic cap_evt;            // selected capture event occurred
  logic norm_cap;           // plain capture
  logic caw_evt;            // capture treated as wrap
  logic match;              // traffic passes filter
  logic [15:0] inc;         // scaled increment
  logic [SCNT_W_L:0] s_sum; // short sum with carry
  logic [bwm_pkg::LCNT_W:0] l_sum;
  logic s_wrap;
  logic l_wrap;
  logic s_cnt_en;
  logic l_cnt_en;
  logic s_snap;             // short snapshot this cycle
  logic l_snap;             // long snapshot this cycle
  logic s_wr;
  logic l_wr;
  logic [31:0] scaled;

  assign cv = ctl_view(ctl_q);
  assign sel = cv[bwm_pkg::B_SEL_HI:bwm_pkg::B_SEL_LO];
  assign s_wr = hit(REG_WR_I, REG_ADDR_I, bwm_pkg::OFF_SCNT);
  assign l_wr = hit(REG_WR_I, REG_ADDR_I, bwm_pkg::OFF_LCNT);

  // capture source decode, absent sources never fire
  always_comb
  begin
    cap_evt = 1'b0;
    if (sel == bwm_pkg::SEL_SW)
      cap_evt = SW_TRIGGER_OWN_STATE_I;
    else if (sel != bwm_pkg::SEL_NONE)
      cap_evt = EXT_CAPTURE_I[sel - 3'h1] && EXT_PRESENT[sel - 3'h1];
  end

  // capture either copies or behaves as a wrap
  assign norm_cap = cap_evt && !cv[bwm_pkg::B_CAW];
  assign caw_evt = cap_evt && cv[bwm_pkg::B_CAW];

  // label filters
  assign match = cv[bwm_pkg::B_EN] && BEAT_VALID_I
    && (!cv[bwm_pkg::B_GRP]
        || BEAT_MONITOR_GROUP_LABEL_I == flt_q[FLT_GRP_HI:FLT_GRP_LO])
    && (!cv[bwm_pkg::B_PART]
        || BEAT_PARTITION_LABEL_I == flt_q[FLT_PART_HI:FLT_PART_LO]);

  // optional right shift of bytes
  assign scaled = {16'h0000, BEAT_BYTES_I} >> SCALE;
  assign inc = cv[bwm_pkg::B_SHEN] ? scaled[15:0] : BEAT_BYTES_I;

  assign s_cnt_en = match && !sfrz_q && !s_wr;
  assign l_cnt_en = HAS_LONG && match && !lfrz_q && !l_wr;
  assign s_sum = {1'b0, scnt_q} + {{(SCNT_W_L-15){1'b0}}, inc};
  assign l_sum = {1'b0, lcnt_q} + {{(bwm_pkg::LCNT_W-15){1'b0}}, inc};
  assign s_wrap = (HAS_OFLOW && s_cnt_en && s_sum[SCNT_W_L]) || caw_evt;
  assign l_wrap = (HAS_LONG && l_cnt_en && l_sum[bwm_pkg::LCNT_W])
    || (HAS_LONG && caw_evt);

  // snapshot causes: normal capture or wrap with snapshot enabled
  assign s_snap = norm_cap || (s_wrap && cv[bwm_pkg::B_SNAP]);
  assign l_snap = HAS_LONG && (norm_cap || (l_wrap && cv[bwm_pkg::B_LSNAP]));

  // linkage: own wrap signals a numbered capture event
  always_comb
  begin
    LINK_CAPTURE_O = 6'h00;
    if (s_wrap && cv[bwm_pkg::B_LNK_HI:bwm_pkg::B_LNK_LO] != 3'h0
        && cv[bwm_pkg::B_LNK_HI:bwm_pkg::B_LNK_LO] != 3'h7)
      LINK_CAPTURE_O[cv[bwm_pkg::B_LNK_HI:bwm_pkg::B_LNK_LO] - 3'h1] = 1'b1;
  end

  // -------------------------------------------------------------------------
  // control register
  // -------------------------------------------------------------------------
  // software writes; hardware sets the sticky flags, set beats clear
  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      ctl_q <= bwm_pkg::CTL_RESET;
    else
    begin
      if (hit(REG_WR_I, REG_ADDR_I, bwm_pkg::OFF_CTL))
        ctl_q <= REG_WDATA_I;
      else
      begin
        if (s_wr && ctl_q[bwm_pkg::B_SWF] && (HAS_CAW || HAS_LNKG))
          ctl_q[bwm_pkg::B_SWF] <= 1'b0;
        if (l_wr && ctl_q[bwm_pkg::B_LWF] && (HAS_CAW || HAS_LNKG))
          ctl_q[bwm_pkg::B_LWF] <= 1'b0;
      end
      if (s_wrap)
        ctl_q[bwm_pkg::B_SWF] <= 1'b1;
      if (l_wrap)
        ctl_q[bwm_pkg::B_LWF] <= 1'b1;
    end
  end

  // filter register
  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      flt_q <= 32'h0000_0000;
    else if (hit(REG_WR_I, REG_ADDR_I, bwm_pkg::OFF_FLT))
      flt_q <= REG_WDATA_I;
  end

  // -------------------------------------------------------------------------
  // short counter
  // -------------------------------------------------------------------------
  // count, wrap or freeze; clear follows the snapshot
  // a store always wins, so software can unfreeze even during a wrap
  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      scnt_q <= '0;
      sfrz_q <= 1'b0;
    end
    else
    begin
      if (s_wr)
      begin
        scnt_q <= REG_WDATA_I[SCNT_W_L-1:0];
        sfrz_q <= 1'b0;
      end
      else if (s_snap && cv[bwm_pkg::B_CLR])
        scnt_q <= '0;
      else if (s_cnt_en)
        scnt_q <= s_sum[SCNT_W_L-1:0];
      if (!s_wr && (s_wrap || (HAS_LONG && l_wrap)) && cv[bwm_pkg::B_FRZ])
        sfrz_q <= 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // long counter
  // -------------------------------------------------------------------------
  // same scheme as the short counter; only the low word reaches the bus,
  // so software sees the upper bits only through a freeze or a wrap flag
  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      lcnt_q <= '0;
      lfrz_q <= 1'b0;
    end
    else if (HAS_LONG)
    begin
      if (l_wr)
      begin
        lcnt_q <= {12'h000, REG_WDATA_I};
        lfrz_q <= 1'b0;
      end
      else if (l_snap && cv[bwm_pkg::B_CLR])
        lcnt_q <= '0;
      else if (l_cnt_en)
        lcnt_q <= l_sum[bwm_pkg::LCNT_W-1:0];
      if (!l_wr && (s_wrap || l_wrap) && cv[bwm_pkg::B_FRZ])
        lfrz_q <= 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // snapshots
  // -------------------------------------------------------------------------
  // copy not-ready flag and pre-clear value
  // flag and value are taken on one edge so the pair is always coherent
  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      scap_q <= 32'h0000_0000;
      lcap_q <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      if (s_snap)
        scap_q <= {NOT_READY_FLAG_I, scnt_q};
      if (l_snap)
        lcap_q <= {NOT_READY_FLAG_I, 19'h00000, lcnt_q};
    end
  end

  // -------------------------------------------------------------------------
  // read data and interrupt
  // -------------------------------------------------------------------------
  // registered read mux, unmapped reads zero
  // offsets are distinct constants; the default covers every hole
  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      REG_RDATA_O <= 32'h0000_0000;
    else if (REG_RD_I)
    begin
      unique case (REG_ADDR_I)
        bwm_pkg::OFF_CTL: REG_RDATA_O <= cv;
        bwm_pkg::OFF_FLT: REG_RDATA_O <= flt_q;
        bwm_pkg::OFF_SCNT: REG_RDATA_O <= {NOT_READY_FLAG_I, scnt_q};
        bwm_pkg::OFF_SCAP: REG_RDATA_O <= scap_q;
        bwm_pkg::OFF_LCNT: REG_RDATA_O <= lcnt_q[31:0];
        bwm_pkg::OFF_LCAP: REG_RDATA_O <= lcap_q[31:0];
        default: REG_RDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  // level interrupt from flag and enable
  assign SHORT_WRAP_IRQ_O = cv[bwm_pkg::B_SWF] && cv[bwm_pkg::B_SIE];
endmodule

// ===== logic/bwm_pkg.sv
// package: register layout, field positions and type constant for the
// bandwidth monitor control block; assumes 32-bit memory-mapped frames.
package bwm_pkg;
  // -------------------------------------------------------------------------
  // register offsets within the feature frame
  // -------------------------------------------------------------------------
  localparam logic [11:0] OFF_CTL = 12'h828;   // bandwidth_monitor_control
  localparam logic [11:0] OFF_FLT = 12'h82C;   // bandwidth_monitor_filter
  localparam logic [11:0] OFF_SCNT = 12'h860;  // short_byte_counter
  localparam logic [11:0] OFF_SCAP = 12'h864;  // short_counter_snapshot
  localparam logic [11:0] OFF_LCNT = 12'h880;  // long_byte_counter low word
  localparam logic [11:0] OFF_LCAP = 12'h890;  // long_counter_snapshot low word
  localparam logic [11:0] OFF_TRIG = 12'h808;  // software_snapshot_trigger
  // -------------------------------------------------------------------------
  // control field positions
  // -------------------------------------------------------------------------
  localparam int B_EN = 31;
  localparam int B_SEL_HI = 30;
  localparam int B_SEL_LO = 28;
  localparam int B_CLR = 27;
  localparam int B_SWF = 26;
  localparam int B_SIE = 25;
  localparam int B_FRZ = 24;
  localparam int B_SNAP = 23;
  localparam int B_SHEN = 19;
  localparam int B_CAW = 18;
  localparam int B_GRP = 17;
  localparam int B_PART = 16;
  localparam int B_LWF = 15;
  localparam int B_LSNAP = 13;
  localparam int B_LNK_HI = 10;
  localparam int B_LNK_LO = 8;
  // -------------------------------------------------------------------------
  // field encodings and constants
  // -------------------------------------------------------------------------
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_SW = 3'h7;
  localparam logic [7:0] MON_TYPE = 8'h42;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam int SCNT_W = 31;
  localparam int LCNT_W = 44;
endpackage

// ===== dv/bwm_ctl_checker.sv
// checker: register port, interrupt and linkage relations of bwm_ctl.
// assumes one register access a cycle and read data one cycle after the read.
module bwm_ctl_checker (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  // register port
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [11:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic [31:0] REG_RDATA_O,
  // linkage and interrupt
  input wire logic [5:0] LINK_CAPTURE_O,
  input wire logic SHORT_WRAP_IRQ_O
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------------------
  // shadow of the control fields that only software changes
  // --------------------------------------------------------------------------
  localparam logic [31:0] SW_MASK = 32'hFB8F_0700;  // enable, select, modes, linkage
  logic [31:0] shadow_q;  // last control write, software fields only
  logic ctl_wr;  // write to the control register
  logic ctl_rd;  // read of the control register
  assign ctl_wr = REG_WR_I && (REG_ADDR_I == bwm_pkg::OFF_CTL);
  assign ctl_rd = REG_RD_I && (REG_ADDR_I == bwm_pkg::OFF_CTL);
  // follow every control write, as the design does on the same edge
  always_ff @(posedge CLOCK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      shadow_q <= 32'h0000_0000;
    end
    else if (ctl_wr)
    begin
      shadow_q <= REG_WDATA_I & SW_MASK;
    end
  end
  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!ARST_N_I);
  chk_type_const: assert property (ctl_rd |=> REG_RDATA_O[7:0] == bwm_pkg::MON_TYPE)
    else $error("control read lost the monitor type");
  chk_subtype_zero: assert property (ctl_rd |=> REG_RDATA_O[22:20] == 3'h0)
    else $error("subtype field not zero");
  chk_ctl_fields: assert property (ctl_rd |=> (REG_RDATA_O & SW_MASK) == $past(shadow_q))
    else $error("control fields differ from last write");
  chk_irq_needs_en: assert property (SHORT_WRAP_IRQ_O |-> shadow_q[bwm_pkg::B_SIE])
    else $error("interrupt without its enable");
  chk_irq_off_write: assert property (ctl_wr && !REG_WDATA_I[25] |=> !SHORT_WRAP_IRQ_O)
    else $error("interrupt stayed after enable cleared");
  chk_irq_status: assert property (ctl_rd |=>
    (REG_RDATA_O[26] & REG_RDATA_O[25]) == $past(SHORT_WRAP_IRQ_O))
    else $error("interrupt level differs from flag and enable");
  chk_link_onehot: assert property ($onehot0(LINK_CAPTURE_O))
    else $error("more than one linkage event at once");
  chk_link_select: assert property (LINK_CAPTURE_O != 6'h00 |-> shadow_q[10:8] != 3'h0 &&
    LINK_CAPTURE_O == (6'h01 << (shadow_q[10:8] - 3'h1)))
    else $error("linkage event differs from linkage field");
endmodule

bind bwm_ctl bwm_ctl_checker chk_u (
  .CLOCK_I(CLOCK_I),
  .ARST_N_I(ARST_N_I),
  .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I),
  .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I),
  .REG_RDATA_O(REG_RDATA_O),
  .LINK_CAPTURE_O(LINK_CAPTURE_O),
  .SHORT_WRAP_IRQ_O(SHORT_WRAP_IRQ_O)
);

// ===== dv/testbench.sv
// testbench: self-checking bench for the bandwidth monitor control block.
// assumes bwm_pkg and bwm_ctl compiled first; scale shift set to 2,
// external capture event 6 left out of the build.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // one counting case: settings, one beat, expected count
  typedef struct {
    logic [31:0] ctl;
    logic [31:0] flt;
    logic [15:0] nb;
    logic [15:0] pt;
    logic [7:0] gp;
    logic [30:0] ex;
  } bwm_row_t;
  // --------------------------------------------------------------------------
  // stimulus and observed signals
  // --------------------------------------------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic beat_valid = 1'b0;
  logic [15:0] beat_bytes = 16'h0000;
  logic [15:0] beat_part = 16'h0000;
  logic [7:0] beat_grp = 8'h00;
  logic [5:0] ext_cap = 6'h00;
  logic sw_trig = 1'b0;
  logic not_ready_flag = 1'b0;  // not-ready flag towards the snapshots
  logic [5:0] link_cap;
  logic irq;
  int n_errors = 0;
  int compares = 0;
  logic [31:0] rv;  // last read data
  logic [30:0] snap;  // expected snapshot
  logic [6:0] ev;  // matching capture event
  bwm_row_t rows [10];
  // 200 MHz clock
  always #2.5 clk = ~clk;
  bwm_ctl #(.SCALE(5'h02), .EXT_PRESENT(6'h1F)) dut_u (
    .CLOCK_I(clk),
    .ARST_N_I(arst_n),
    .REG_WR_I(reg_wr),
    .REG_RD_I(reg_rd),
    .REG_ADDR_I(reg_addr),
    .REG_WDATA_I(reg_wdata),
    .REG_RDATA_O(reg_rdata),
    .BEAT_VALID_I(beat_valid),
    .BEAT_BYTES_I(beat_bytes),
    .BEAT_PARTITION_LABEL_I(beat_part),
    .BEAT_MONITOR_GROUP_LABEL_I(beat_grp),
    .NOT_READY_FLAG_I(not_ready_flag),
    .EXT_CAPTURE_I(ext_cap),
    .SW_TRIGGER_OWN_STATE_I(sw_trig),
    .LINK_CAPTURE_O(link_cap),
    .SHORT_WRAP_IRQ_O(irq)
  );
  // --------------------------------------------------------------------------
  // shared tasks; each starts and ends just after a rising edge
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    rv = reg_rdata;
  endtask
  task automatic beat(input logic [15:0] nb, input logic [15:0] pt, input logic [7:0] gp);
    beat_valid <= 1'b1;
    beat_bytes <= nb;
    beat_part <= pt;
    beat_grp <= gp;
    @(posedge clk);
    beat_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic [6:0] v);
    ext_cap <= v[5:0];
    sw_trig <= v[6];
    @(posedge clk);
    ext_cap <= 6'h00;
    sw_trig <= 1'b0;
    @(posedge clk);
  endtask
  // counts, verdict and end of run
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end
  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    rows[0] = '{32'h0000_0000, 32'h0, 16'h0040, 16'h0012, 8'h5A, 31'h0};
    rows[1] = '{32'h8000_0000, 32'h0, 16'h0040, 16'h0012, 8'h5A, 31'h40};
    rows[2] = '{32'h8000_0000, 32'h0, 16'hFFFF, 16'h0000, 8'h00, 31'hFFFF};
    rows[3] = '{32'h8001_0000, 32'h005A_0012, 16'h0040, 16'h0012, 8'h00, 31'h40};
    rows[4] = '{32'h8001_0000, 32'h005A_0012, 16'h0040, 16'h0013, 8'h5A, 31'h0};
    rows[5] = '{32'h8002_0000, 32'h005A_0012, 16'h0040, 16'h0099, 8'h5A, 31'h40};
    rows[6] = '{32'h8002_0000, 32'h005A_0012, 16'h0040, 16'h0012, 8'h5B, 31'h0};
    rows[7] = '{32'h8003_0000, 32'h005A_0012, 16'h0040, 16'h0012, 8'h5A, 31'h40};
    rows[8] = '{32'h8008_0000, 32'h0, 16'h0040, 16'h0000, 8'h00, 31'h10};
    rows[9] = '{32'h8000_0000, 32'h005A_0012, 16'h0040, 16'h0013, 8'h5B, 31'h40};
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    // reset value, unmapped place, read-only and reserved fields
    rd(bwm_pkg::OFF_CTL);
    check(rv, 32'h0000_0042);
    rd(12'h7FC);
    check(rv, 32'h0000_0000);
    wr(bwm_pkg::OFF_CTL, 32'h1BFF_03FF);
    rd(bwm_pkg::OFF_CTL);
    check(rv, 32'h1B8F_0342);
    $display("test reset_fields done");
    // ordinary counting cases
    foreach (rows[i])
    begin
      wr(bwm_pkg::OFF_CTL, rows[i].ctl);
      wr(bwm_pkg::OFF_FLT, rows[i].flt);
      wr(bwm_pkg::OFF_SCNT, 32'h0000_0000);
      beat(rows[i].nb, rows[i].pt, rows[i].gp);
      rd(bwm_pkg::OFF_SCNT);
      check({1'b0, rv[30:0]}, {1'b0, rows[i].ex});
    end
    $display("test counting_rows done");
    // every capture source, wrong events first, then the matching one
    snap = 31'h0;
    for (int s = 0; s < 8; s++)
    begin
      ev = 7'((1 << s) >> 1);
      wr(bwm_pkg::OFF_SCNT, 32'(256 + s));
      wr(bwm_pkg::OFF_LCNT, 32'(512 + s));
      wr(bwm_pkg::OFF_CTL, {1'b1, 3'(s), 28'h800_0000});
      pulse(~ev);
      rd(bwm_pkg::OFF_SCAP);
      check({1'b0, rv[30:0]}, {1'b0, snap});
      pulse(ev);
      snap = (s == 0 || s == 6) ? snap : 31'(256 + s);
      rd(bwm_pkg::OFF_SCAP);
      check({1'b0, rv[30:0]}, {1'b0, snap});
      rd(bwm_pkg::OFF_SCNT);
      check({1'b0, rv[30:0]}, (s == 0 || s == 6) ? 32'(256 + s) : 32'h0);
      rd(bwm_pkg::OFF_LCAP);
      check(rv, (s == 0) ? 32'h0 : (s == 6) ? 32'h205 : 32'(512 + s));
    end
    $display("test capture_sources done");
    // wrap with freeze, interrupt, linkage, then counter store
    wr(bwm_pkg::OFF_CTL, 32'h8300_0300);
    wr(bwm_pkg::OFF_SCNT, 32'h7FFF_FFFF);
    beat(16'h0001, 16'h0000, 8'h00);
    beat(16'h0005, 16'h0000, 8'h00);
    rd(bwm_pkg::OFF_SCNT);
    check({1'b0, rv[30:0]}, 32'h0);
    check({31'h0, irq}, 32'h1);
    rd(bwm_pkg::OFF_CTL);
    check(rv, 32'h8700_0342);
    wr(bwm_pkg::OFF_SCNT, 32'h0000_0010);
    check({31'h0, irq}, 32'h0);
    rd(bwm_pkg::OFF_CTL);
    check(rv, 32'h8300_0342);
    beat(16'h0004, 16'h0000, 8'h00);
    rd(bwm_pkg::OFF_SCNT);
    check({1'b0, rv[30:0]}, 32'h14);
    $display("test freeze_irq done");
    // wrap without freeze, then a capture event taken as a wrap
    wr(bwm_pkg::OFF_CTL, 32'h8000_0000);
    wr(bwm_pkg::OFF_SCNT, 32'h7FFF_FFFE);
    beat(16'h0003, 16'h0000, 8'h00);
    rd(bwm_pkg::OFF_SCNT);
    check({1'b0, rv[30:0]}, 32'h1);
    rd(bwm_pkg::OFF_CTL);
    check(rv, 32'h8400_0042);
    wr(bwm_pkg::OFF_CTL, 32'h9004_0000);
    pulse(7'h01);
    rd(bwm_pkg::OFF_CTL);
    check(rv, 32'h9404_8042);
    rd(bwm_pkg::OFF_SCAP);
    check({1'b0, rv[30:0]}, 32'h107);
    // snapshot on a wrap taken from a capture event, with clear after it
    wr(bwm_pkg::OFF_CTL, 32'h9884_0000);
    not_ready_flag <= 1'b1;
    pulse(7'h01);
    not_ready_flag <= 1'b0;
    rd(bwm_pkg::OFF_SCAP);
    check(rv, 32'h8000_0001);
    rd(bwm_pkg::OFF_SCNT);
    check(rv, 32'h0000_0000);
    rd(bwm_pkg::OFF_LCAP);
    check(rv, 32'h0000_0207);
    $display("test wrap_modes done");
    // reset in mid-run returns flags, snapshots and control to zero
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(bwm_pkg::OFF_CTL);
    check(rv, 32'h0000_0042);
    rd(bwm_pkg::OFF_SCAP);
    check(rv, 32'h0000_0000);
    $display("test midrun_reset done");
    complete_run();
  end
endmodule
